// [include/clr_pkg.sv]
`default_nettype none
package clr_pkg;

	// Bytes on the link and the address pointer.
	typedef logic [7:0] clr_byte_t;
	typedef logic [6:0] clr_ptr_t;
	typedef logic [3:0] clr_nib_t;

	// Timing: every internal operation keeps the busy flag up this long.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned EXEC_TIME_NS = 38000;
	localparam int unsigned EXEC_CYC = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host enable pulse: high this many cycles, then low as many.
	localparam int unsigned STROBE_CYC = 4;
	// Cycles from a prefetch request to the output data register load.
	localparam logic [1:0] PF_LAT = 2'h2;

	// Instruction field positions.
	localparam int BIT_BUSY = 7;
	localparam int BIT_WIDE = 4;
	localparam int BIT_N = 3;
	localparam int BIT_F = 2;
	localparam int BIT_ID = 1;
	localparam int BIT_SC = 3;
	localparam int BIT_RL = 2;

	// Text and glyph memory geometry.
	localparam clr_ptr_t PTR_ZERO = 7'h00;
	localparam clr_ptr_t PTR_ONE = 7'h01;
	localparam clr_ptr_t TXT_1L_LAST = 7'h4F;
	localparam clr_ptr_t TXT_L1_LAST = 7'h27;
	localparam clr_ptr_t TXT_L2_FIRST = 7'h40;
	localparam clr_ptr_t TXT_L2_LAST = 7'h67;
	localparam clr_ptr_t TXT_LINE_LEN = 7'h28;
	localparam clr_ptr_t TXT_NONE = 7'h7F;
	localparam clr_ptr_t GLY_MASK = 7'h3F;
	localparam int TXT_DEPTH = 80;
	localparam int GLY_DEPTH = 64;
	localparam int GLY_AW = 6;
	localparam int GLY_ROW_W = 3;
	localparam int GLY_PIX_W = 5;
	localparam clr_nib_t USER_CODE_HI = 4'h0;

	// Host register map and fields.
	localparam logic [3:0] WB_CMD_OFS = 4'h0;
	localparam logic [3:0] WB_STAT_OFS = 4'h4;
	localparam int CMD_SEL_BIT = 8;
	localparam int CMD_RW_BIT = 9;
	localparam int ST_ACTIVE = 0;
	localparam int ST_FOUR = 1;
	localparam int ST_SUSPECT = 2;
	localparam int ST_SHIFT = 3;
	localparam int ST_RX_LSB = 8;

	// Instruction decoding shared by both ends.
	function automatic logic is_func_set(input clr_byte_t b);
		is_func_set = (b[7:5] == 3'h1);
	endfunction

	function automatic logic is_entry(input clr_byte_t b);
		is_entry = (b[7:2] == 6'h01);
	endfunction

	function automatic logic is_shift(input clr_byte_t b);
		is_shift = (b[7:4] == 4'h1);
	endfunction

	function automatic logic is_glyph_addr(input clr_byte_t b);
		is_glyph_addr = (b[7:6] == 2'h1);
	endfunction

	function automatic logic is_text_addr(input clr_byte_t b);
		is_text_addr = b[7];
	endfunction

	// Lane placement: narrow mode carries nibbles on the top four lines, high first.
	function automatic clr_byte_t lane_out(input clr_byte_t b, input logic wide, input logic second);
		if (wide)
			lane_out = b;
		else if (second)
			lane_out = {b[3:0], USER_CODE_HI};
		else
			lane_out = {b[7:4], USER_CODE_HI};
	endfunction

endpackage
`default_nettype wire

// [include/clr_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Parallel link between host and display controller; the shared data lines
// are resolved here from the two active-low enables, idling high.
interface clr_link_if;
	logic reg_sel;
	logic rd_wr;
	logic en;
	logic [7:0] host_d;
	logic host_d_oe_n;
	logic [7:0] dev_d;
	logic dev_d_oe_n;
	logic [7:0] data;

	// Host wins a clash; the protocol keeps the two enables apart.
	assign data = !host_d_oe_n ? host_d : (!dev_d_oe_n ? dev_d : '1);

	modport host (output reg_sel, output rd_wr, output en, output host_d, output host_d_oe_n,
		input data);
	modport dev (input reg_sel, input rd_wr, input en, input data, output dev_d,
		output dev_d_oe_n);
endinterface
`default_nettype wire

// [hdl/clr_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module clr_ram #(
	parameter int DW = 8,
	parameter int AW = 7,
	parameter int DEPTH = 80
)(
	// Clock.
	input wire logic clk_i,
	// Port A: read and write.
	input wire logic a_we_i,
	input wire logic [AW-1:0] a_addr_i,
	input wire logic [DW-1:0] a_wdata_i,
	output var logic [DW-1:0] a_rdata_o,
	// Port B: read only.
	input wire logic [AW-1:0] b_addr_i,
	output var logic [DW-1:0] b_rdata_o
);
	localparam logic [AW:0] LIM = (AW + 1)'(DEPTH);

	logic [DW-1:0] mem [DEPTH];

	// Addresses past the array are dropped on write and read as zero.
	always_ff @(posedge clk_i)
	begin
		if (a_we_i && {1'b0, a_addr_i} < LIM)
			mem[a_addr_i] <= a_wdata_i;
	end

	// Both reads are registered, so data lags the address by one cycle.
	always_ff @(posedge clk_i)
	begin
		a_rdata_o <= ({1'b0, a_addr_i} < LIM) ? mem[a_addr_i] : '0;
		b_rdata_o <= ({1'b0, b_addr_i} < LIM) ? mem[b_addr_i] : '0;
	end
endmodule
`default_nettype wire

// [hdl/clr_dev.sv]
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module clr_dev #(
	parameter int unsigned EXEC_CYCLES = clr_pkg::EXEC_CYC,
	parameter int TEXT_DEPTH = clr_pkg::TXT_DEPTH,
	parameter int GLYPH_DEPTH = clr_pkg::GLY_DEPTH
)(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Link to the host.
	clr_link_if.dev link,
	// Display scan of text memory.
	input wire clr_pkg::clr_ptr_t scan_addr_i,
	output var clr_pkg::clr_byte_t scan_char_o,
	// Glyph lookup for the display scan.
	input wire clr_pkg::clr_byte_t glyph_code_i,
	input wire logic [clr_pkg::GLY_ROW_W-1:0] glyph_row_i,
	output var logic [clr_pkg::GLY_PIX_W-1:0] glyph_pix_o,
	output var logic glyph_user_o,
	// Mode and status.
	output var logic wide_bus_o,
	output var logic two_line_o,
	output var logic tall_font_o,
	output var logic busy_o
);
	import clr_pkg::*;

	localparam int CNT_W = $clog2(EXEC_CYCLES + 1);

	// Map a text address to a memory row; holes in two-line mode map off the end.
	function automatic clr_ptr_t txt_index(input clr_ptr_t p, input logic two);
		txt_index = p;
		if (two)
		begin
			if (p >= TXT_L2_FIRST && p <= TXT_L2_LAST)
				txt_index = p - TXT_L2_FIRST + TXT_LINE_LEN;
			else if (p > TXT_L1_LAST)
				txt_index = TXT_NONE;
		end
		else if (p > TXT_1L_LAST)
			txt_index = TXT_NONE;
	endfunction

	// Next pointer value, wrapping within the valid ranges.
	function automatic clr_ptr_t step_ptr(input clr_ptr_t p, input logic up, input logic gly,
		input logic two);
		if (gly)
			step_ptr = (up ? p + PTR_ONE : p - PTR_ONE) & GLY_MASK;
		else if (up)
			step_ptr = (two && p == TXT_L1_LAST) ? TXT_L2_FIRST :
				((p == (two ? TXT_L2_LAST : TXT_1L_LAST)) ? PTR_ZERO : p + PTR_ONE);
		else
			step_ptr = (two && p == TXT_L2_FIRST) ? TXT_L1_LAST :
				((p == PTR_ZERO) ? (two ? TXT_L2_LAST : TXT_1L_LAST) : p - PTR_ONE);
	endfunction

	logic en_q;
	logic wide_q;
	logic two_line_q;
	logic inc_q;
	logic glyph_sel_q;
	logic nib_q;
	clr_nib_t hi_nib_q;
	clr_ptr_t ptr_q;
	clr_byte_t rd_q;
	clr_byte_t dout_q;
	logic oe_n_q;
	logic [CNT_W-1:0] busy_cnt_q;
	logic [1:0] pf_q;
	logic strobe;
	logic byte_done;
	logic cmd_wr;
	logic dat_wr;
	logic dat_rd;
	logic shift_cur;
	logic prefetch;
	clr_byte_t byte_in;
	clr_byte_t reply;
	clr_byte_t txt_rdata;
	clr_byte_t gly_rdata;
	clr_byte_t gly_scan;

	// Transfers are taken on the first cycle the enable is seen high.
	assign strobe = link.en && !en_q;
	assign byte_in = wide_q ? link.data : {hi_nib_q, link.data[7:4]};
	assign byte_done = strobe && (wide_q || nib_q);
	assign cmd_wr = byte_done && !link.rd_wr && !link.reg_sel;
	assign dat_wr = byte_done && !link.rd_wr && link.reg_sel;
	assign dat_rd = byte_done && link.rd_wr && link.reg_sel;
	assign shift_cur = cmd_wr && is_shift(byte_in) && !byte_in[BIT_SC];
	assign busy_o = (busy_cnt_q != '0);
	// Cursor shift refills the read register only for text memory.
	assign prefetch = dat_rd || (cmd_wr && (is_glyph_addr(byte_in) || is_text_addr(byte_in)))
		|| (shift_cur && !glyph_sel_q);
	assign reply = link.reg_sel ? rd_q : {busy_o, ptr_q};

	// Edge detector on the host enable.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			en_q <= 1'b0;
		else
			en_q <= link.en;
	end

	// Nibble phase: a function set that widens the bus also realigns the phase.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nib_q <= 1'b0;
			hi_nib_q <= '0;
		end
		else if (cmd_wr && is_func_set(byte_in) && byte_in[BIT_WIDE])
			nib_q <= 1'b0;
		else if (strobe && !wide_q)
		begin
			nib_q <= !nib_q;
			hi_nib_q <= link.data[7:4];
		end
	end

	// Function set and entry mode; power-up is the wide bus, one line, short font.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wide_q <= 1'b1;
			two_line_q <= 1'b0;
			tall_font_o <= 1'b0;
			inc_q <= 1'b1;
		end
		else if (cmd_wr && is_func_set(byte_in))
		begin
			wide_q <= byte_in[BIT_WIDE];
			two_line_q <= byte_in[BIT_N];
			tall_font_o <= byte_in[BIT_F];
		end
		else if (cmd_wr && is_entry(byte_in))
			inc_q <= byte_in[BIT_ID];
	end

	// Address pointer and memory select.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ptr_q <= PTR_ZERO;
			glyph_sel_q <= 1'b0;
		end
		else if (cmd_wr && is_text_addr(byte_in))
		begin
			ptr_q <= byte_in[6:0];
			glyph_sel_q <= 1'b0;
		end
		else if (cmd_wr && is_glyph_addr(byte_in))
		begin
			ptr_q <= byte_in[6:0] & GLY_MASK;
			glyph_sel_q <= 1'b1;
		end
		else if (shift_cur)
			ptr_q <= step_ptr(ptr_q, byte_in[BIT_RL], glyph_sel_q, two_line_q);
		else if (dat_wr || dat_rd)
			ptr_q <= step_ptr(ptr_q, inc_q, glyph_sel_q, two_line_q);
	end

	// Refilled two cycles after a prefetch, once the pointer has moved and memory read it;
	// writes never refill it, so a read straight after a write returns the older byte.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pf_q <= '0;
			rd_q <= '0;
		end
		else if (prefetch)
			pf_q <= PF_LAT;
		else if (pf_q != '0)
		begin
			pf_q <= pf_q - 2'h1;
			if (pf_q == 2'h1)
				rd_q <= glyph_sel_q ? gly_rdata : txt_rdata;
		end
	end

	// Busy timer; a status read starts no operation.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_cnt_q <= '0;
		else if (byte_done && (link.reg_sel || !link.rd_wr))
			busy_cnt_q <= CNT_W'(EXEC_CYCLES);
		else if (busy_o)
			busy_cnt_q <= busy_cnt_q - 1'b1;
	end

	// Read drive: data is loaded at the take and held while the enable stays high.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dout_q <= '0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			oe_n_q <= !(link.en && link.rd_wr);
			if (strobe && link.rd_wr)
				dout_q <= lane_out(reply, wide_q, nib_q);
		end
	end

	// A glyph code's user flag is delayed to line up with the registered pixels.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			glyph_user_o <= 1'b0;
		else
			glyph_user_o <= (glyph_code_i[7:4] == USER_CODE_HI);
	end

	clr_ram #(.DW(8), .AW(7), .DEPTH(TEXT_DEPTH)) u_text (
		.clk_i(clk_i),
		.a_we_i(dat_wr && !glyph_sel_q),
		.a_addr_i(txt_index(ptr_q, two_line_q)),
		.a_wdata_i(byte_in),
		.a_rdata_o(txt_rdata),
		.b_addr_i(txt_index(scan_addr_i, two_line_q)),
		.b_rdata_o(scan_char_o)
	);

	// Glyph number forms the upper address bits, the row the lower ones.
	clr_ram #(.DW(8), .AW(GLY_AW), .DEPTH(GLYPH_DEPTH)) u_glyph (
		.clk_i(clk_i),
		.a_we_i(dat_wr && glyph_sel_q),
		.a_addr_i(ptr_q[GLY_AW-1:0]),
		.a_wdata_i(byte_in),
		.a_rdata_o(gly_rdata),
		.b_addr_i({glyph_code_i[GLY_ROW_W-1:0], glyph_row_i}),
		.b_rdata_o(gly_scan)
	);

	assign glyph_pix_o = gly_scan[GLY_PIX_W-1:0];
	assign link.dev_d = dout_q;
	assign link.dev_d_oe_n = oe_n_q;
	assign wide_bus_o = wide_q;
	assign two_line_o = two_line_q;
endmodule
`default_nettype wire

// [hdl/clr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module clr_host #(
	parameter int unsigned STROBE = clr_pkg::STROBE_CYC
)(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output var logic [31:0] wb_dat_o,
	output var logic wb_ack_o,
	// Link to the display controller.
	clr_link_if.host link
);
	import clr_pkg::*;

	localparam int CW = $clog2(2 * STROBE);
	localparam logic [CW-1:0] HI_END = CW'(STROBE);
	localparam logic [CW-1:0] NIB_END = CW'(2 * STROBE - 1);

	typedef enum logic [1:0] {HS_IDLE, HS_POLL, HS_CMD} clr_hstate_e;

	clr_hstate_e state_q;
	logic [CW-1:0] cnt_q;
	logic nib_q;
	logic four_q;
	logic ack_q;
	logic [31:0] dat_q;
	clr_byte_t cmd_q;
	logic cmd_sel_q;
	logic cmd_rw_q;
	clr_byte_t rx_q;
	clr_byte_t last_q;
	logic addr_seen_q;
	logic glyph_q;
	logic glyph_rd_q;
	logic suspect_q;
	logic shift_risk_q;
	logic en_q;
	logic sel_q;
	logic rw_q;
	clr_byte_t hd_q;
	logic hoe_n_q;
	logic active;
	logic cur_sel;
	logic cur_rw;
	logic go;
	logic byte_end;
	logic cmd_done;

	assign active = (state_q != HS_IDLE);
	// Every command is preceded by status reads until the busy flag is low.
	assign cur_sel = (state_q == HS_CMD) && cmd_sel_q;
	assign cur_rw = (state_q == HS_POLL) || cmd_rw_q;
	assign go = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && (wb_adr_i == WB_CMD_OFS)
		&& (wb_sel_i[1:0] == 2'h3) && !active;
	assign byte_end = active && (cnt_q == NIB_END) && (!four_q || nib_q);
	assign cmd_done = byte_end && (state_q == HS_CMD);

	// Bus slave: answers one cycle after the request, unmapped reads are zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			dat_q <= '0;
			if (wb_adr_i == WB_CMD_OFS)
				dat_q <= {22'h0, cmd_rw_q, cmd_sel_q, cmd_q};
			else if (wb_adr_i == WB_STAT_OFS)
				dat_q <= {16'h0, last_q, 4'h0, shift_risk_q, suspect_q, four_q, active};
		end
	end

	// Command latch; a write while a transfer runs is dropped.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_q <= '0;
			cmd_sel_q <= 1'b0;
			cmd_rw_q <= 1'b0;
		end
		else if (go)
		begin
			cmd_q <= wb_dat_i[7:0];
			cmd_sel_q <= wb_dat_i[CMD_SEL_BIT];
			cmd_rw_q <= wb_dat_i[CMD_RW_BIT];
		end
	end

	// Transfer engine: per nibble, enable high for STROBE cycles then low as long.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= HS_IDLE;
			cnt_q <= '0;
			nib_q <= 1'b0;
			rx_q <= '0;
		end
		else
		begin
			case (state_q)
				HS_IDLE:
				begin
					cnt_q <= '0;
					nib_q <= 1'b0;
					if (go)
						state_q <= HS_POLL;
				end
				HS_POLL, HS_CMD:
				begin
					// Sample in the last enable-high cycle; high nibble arrives first.
					if (cnt_q == HI_END)
						rx_q <= four_q ? (nib_q ? {rx_q[7:4], link.data[7:4]}
							: {link.data[7:4], rx_q[3:0]}) : link.data;
					cnt_q <= (cnt_q == NIB_END) ? '0 : cnt_q + 1'b1;
					if (cnt_q == NIB_END)
						nib_q <= four_q && !nib_q;
					if (byte_end && state_q == HS_POLL && !rx_q[BIT_BUSY])
						state_q <= HS_CMD;
					else if (cmd_done)
						state_q <= HS_IDLE;
				end
				default:
					state_q <= HS_IDLE;
			endcase
		end
	end

	// Link drive, registered from the engine position.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			en_q <= 1'b0;
			sel_q <= 1'b0;
			rw_q <= 1'b1;
			hd_q <= '0;
			hoe_n_q <= 1'b1;
		end
		else
		begin
			en_q <= active && (cnt_q < HI_END) && !byte_end;
			sel_q <= cur_sel;
			rw_q <= cur_rw;
			hd_q <= lane_out(cmd_q, !four_q, nib_q);
			hoe_n_q <= !(active && !cur_rw);
		end
	end

	// Track bus width and address state from the commands actually sent.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			four_q <= 1'b0;
			addr_seen_q <= 1'b0;
			glyph_q <= 1'b0;
			glyph_rd_q <= 1'b0;
			suspect_q <= 1'b0;
			shift_risk_q <= 1'b0;
			last_q <= '0;
		end
		else if (cmd_done)
		begin
			glyph_rd_q <= cmd_sel_q && cmd_rw_q && glyph_q;
			shift_risk_q <= 1'b0;
			if (cmd_rw_q)
				last_q <= rx_q;
			if (cmd_sel_q && cmd_rw_q)
				suspect_q <= !addr_seen_q;
			if (!cmd_sel_q && !cmd_rw_q)
			begin
				if (is_func_set(cmd_q))
					four_q <= !cmd_q[BIT_WIDE];
				if (is_text_addr(cmd_q) || is_glyph_addr(cmd_q))
				begin
					addr_seen_q <= 1'b1;
					glyph_q <= !is_text_addr(cmd_q);
				end
				// A display shift right after a glyph read may misfire; flag it.
				if (is_shift(cmd_q) && cmd_q[BIT_SC])
					shift_risk_q <= glyph_rd_q;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign link.en = en_q;
	assign link.reg_sel = sel_q;
	assign link.rd_wr = rw_q;
	assign link.host_d = hd_q;
	assign link.host_d_oe_n = hoe_n_q;
endmodule
`default_nettype wire

// [dv/clr_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the parallel link between the two ends; both ends share clk_i.
module clr_assertions (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Link signals.
	input wire logic reg_sel,
	input wire logic rd_wr,
	input wire logic en,
	input wire logic [7:0] host_d,
	input wire logic host_d_oe_n,
	input wire logic [7:0] dev_d,
	input wire logic dev_d_oe_n,
	input wire logic [7:0] data
);
	// One domain, so clocking and reset are given once.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// A read strobe makes the device drive for four cycles, starting one edge after enable rises.
	property p_read_drive;
		$rose(en) && rd_wr |=> !dev_d_oe_n [*4];
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("device not driving a read");
	// The device lets go one edge after the read strobe ends.
	property p_read_release;
		$fell(en) && rd_wr |=> dev_d_oe_n;
	endproperty
	a_read_release: assert property (p_read_release) else $error("device holds bus");
	// The device never drives during a write.
	property p_dev_quiet;
		!rd_wr |-> dev_d_oe_n;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet) else $error("device drives on write");
	// Each transfer keeps enable high exactly four cycles.
	property p_strobe;
		$rose(en) |-> en [*4] ##1 !en;
	endproperty
	a_strobe: assert property (p_strobe) else $error("enable width wrong");
	// A low time of four cycles separates transfers.
	property p_gap;
		$fell(en) |-> !en [*4];
	endproperty
	a_gap: assert property (p_gap) else $error("enable gap too short");
	// Qualifiers stay put while the strobe is high.
	property p_host_hold;
		en && $past(en) |-> $stable(reg_sel) && $stable(rd_wr) && $stable(host_d);
	endproperty
	a_host_hold: assert property (p_host_hold) else $error("host changed mid strobe");
	// The host drives the lines for every write.
	property p_host_drive_wr;
		en && !rd_wr |-> !host_d_oe_n;
	endproperty
	a_host_drive_wr: assert property (p_host_drive_wr) else $error("host not driving");
	// The host is off the lines for every read.
	property p_host_quiet_rd;
		en && rd_wr |-> host_d_oe_n;
	endproperty
	a_host_quiet_rd: assert property (p_host_quiet_rd) else $error("host drives read");
	// Two drivers at once would be a bus clash.
	property p_no_clash;
		host_d_oe_n || dev_d_oe_n;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive");
endmodule
`default_nettype wire

// [dv/tb_char_lcd_ram_access_commands.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_char_lcd_ram_access_commands;
	import clr_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
	logic [31:0] wb_wd = 32'h0, wb_rd, rq;
	logic wb_ack, wide, two, tall, busy, guser, en_q = 1'b0;
	clr_ptr_t scan_a = 7'h00;
	clr_byte_t scan_c, gcode = 8'h00, w_prev = 8'h00, w_last = 8'h00;
	logic [2:0] grow = 3'h0;
	logic [4:0] gpix;
	int n_mismatch = 0, check_count = 0;
	// The short busy time keeps the run brief; polling hides its length.
	clr_link_if clr_link_if_i ();
	clr_dev #(.EXEC_CYCLES(40)) clr_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(clr_link_if_i),
		.scan_addr_i(scan_a), .scan_char_o(scan_c), .glyph_code_i(gcode), .glyph_row_i(grow),
		.glyph_pix_o(gpix), .glyph_user_o(guser), .wide_bus_o(wide), .two_line_o(two),
		.tall_font_o(tall), .busy_o(busy));
	clr_host clr_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd),
		.wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .link(clr_link_if_i));
	clr_assertions clr_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
		.reg_sel(clr_link_if_i.reg_sel), .rd_wr(clr_link_if_i.rd_wr), .en(clr_link_if_i.en),
		.host_d(clr_link_if_i.host_d), .host_d_oe_n(clr_link_if_i.host_d_oe_n),
		.dev_d(clr_link_if_i.dev_d), .dev_d_oe_n(clr_link_if_i.dev_d_oe_n),
		.data(clr_link_if_i.data));

	// Free-running bus clock.
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	// Log the wire value of the last two write transfers to see lane order.
	always @(posedge clk_i)
	begin
		if (clr_link_if_i.en && !en_q && !clr_link_if_i.rd_wr)
		begin
			w_prev <= w_last;
			w_last <= clr_link_if_i.data;
		end
		en_q <= clr_link_if_i.en;
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One classic Wishbone cycle; held until ack is sampled high.
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_wd <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 200);
		rq = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 200)
			check("ack", 1'b0, 1'b1);
	endtask

	// Issue one link command and poll until the engine is idle; rq then holds STATUS.
	task cmd(input logic [7:0] b, input logic sel, input logic rd);
		int n;
		n = 0;
		wb(1'b1, WB_CMD_OFS, {22'h0, rd, sel, b});
		do
		begin
			wb(1'b0, WB_STAT_OFS, 32'h0);
			n++;
		end
		while (rq[ST_ACTIVE] !== 1'b0 && n < 300);
	endtask

	task scan(input clr_ptr_t a);
		scan_a <= a;
		repeat (2) @(posedge clk_i);
	endtask

	task glyph(input clr_byte_t c, input logic [2:0] r);
		gcode <= c;
		grow <= r;
		repeat (2) @(posedge clk_i);
	endtask

	// Watchdog sized well above the expected run length.
	initial
	begin
		repeat (80000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end

	initial
	begin
		logic [7:0] fs [4];
		fs = '{8'h34, 8'h3C, 8'h30, 8'h38};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("wide", wide, 1'b1);
		check("busy", busy, 1'b0);
		cmd(8'h00, 1'b0, 1'b1);
		check("status", rq[15:8], 8'h00);
		wb(1'b1, 4'h8, 32'h1234);
		wb(1'b0, 4'h8, 32'h0);
		check("unmapped", rq, 32'h0);
		$display("test reset done");
		// A read with no address set first is flagged.
		cmd(8'h00, 1'b1, 1'b1);
		check("no_addr_flag", rq[ST_SUSPECT], 1'b1);
		check("no_addr_byte", rq[15:8], 8'h00);
		$display("test first read done");
		foreach (fs[i])
		begin
			cmd(fs[i], 1'b0, 1'b0);
			check("two_line", two, fs[i][BIT_N]);
			check("tall", tall, fs[i][BIT_F]);
			check("wide_kept", wide, 1'b1);
		end
		$display("test function set done");
		// Two-line wrap from the end of line one to the start of line two.
		cmd(8'hA7, 1'b0, 1'b0);
		cmd(8'h41, 1'b1, 1'b0);
		cmd(8'h42, 1'b1, 1'b0);
		check("wire_byte", w_last, 8'h42);
		check("busy_set", busy, 1'b1);
		cmd(8'h00, 1'b0, 1'b1);
		check("ptr_wrap", rq[15:8], 8'h41);
		scan(7'h27);
		check("text27", scan_c, 8'h41);
		scan(7'h40);
		check("text40", scan_c, 8'h42);
		cmd(8'hA7, 1'b0, 1'b0);
		cmd(8'h00, 1'b1, 1'b1);
		check("read1", rq[15:8], 8'h41);
		cmd(8'h00, 1'b0, 1'b1);
		check("ptr_read", rq[15:8], 8'h40);
		cmd(8'h00, 1'b1, 1'b1);
		check("read2", rq[15:8], 8'h42);
		$display("test text access done");
		// A read after a write returns the byte fetched at address set.
		cmd(8'hC0, 1'b0, 1'b0);
		cmd(8'h43, 1'b1, 1'b0);
		cmd(8'h00, 1'b1, 1'b1);
		check("stale", rq[15:8], 8'h42);
		cmd(8'h04, 1'b0, 1'b0);
		cmd(8'hC0, 1'b0, 1'b0);
		cmd(8'h44, 1'b1, 1'b0);
		cmd(8'h00, 1'b0, 1'b1);
		check("ptr_dec", rq[15:8], 8'h27);
		cmd(8'h06, 1'b0, 1'b0);
		$display("test prefetch and direction done");
		// One-line mode wraps after 4FH; cursor shift refills the read register.
		cmd(8'h30, 1'b0, 1'b0);
		cmd(8'hCF, 1'b0, 1'b0);
		cmd(8'h45, 1'b1, 1'b0);
		cmd(8'h00, 1'b0, 1'b1);
		check("ptr_1l", rq[15:8], 8'h00);
		scan(7'h4F);
		check("text4F", scan_c, 8'h45);
		cmd(8'hCE, 1'b0, 1'b0);
		cmd(8'h14, 1'b0, 1'b0);
		cmd(8'h00, 1'b1, 1'b1);
		check("shift_fetch", rq[15:8], 8'h45);
		$display("test one line done");
		// Glyph memory: address, stepping and lookup by character code.
		cmd(8'h48, 1'b0, 1'b0);
		cmd(8'h1F, 1'b1, 1'b0);
		cmd(8'h0A, 1'b1, 1'b0);
		cmd(8'h00, 1'b0, 1'b1);
		check("glyph_ptr", rq[15:8], 8'h0A);
		glyph(8'h09, 3'h0);
		check("pix0", gpix, 5'h1F);
		check("user", guser, 1'b1);
		glyph(8'h01, 3'h1);
		check("pix1", gpix, 5'h0A);
		glyph(8'h41, 3'h1);
		check("not_user", guser, 1'b0);
		cmd(8'h48, 1'b0, 1'b0);
		cmd(8'h00, 1'b1, 1'b1);
		check("glyph_read", rq[15:8], 8'h1F);
		cmd(8'h18, 1'b0, 1'b0);
		check("shift_flag", rq[ST_SHIFT], 1'b1);
		$display("test glyph done");
		// Narrow mode: two nibbles per byte, high first on the top lines.
		cmd(8'h20, 1'b0, 1'b0);
		check("narrow", wide, 1'b0);
		check("four_flag", rq[ST_FOUR], 1'b1);
		cmd(8'h85, 1'b0, 1'b0);
		cmd(8'h5A, 1'b1, 1'b0);
		check("nib_hi", w_prev[7:4], 4'h5);
		check("nib_lo", w_last, 8'hA0);
		scan(7'h05);
		check("text05", scan_c, 8'h5A);
		cmd(8'h00, 1'b0, 1'b1);
		check("ptr_narrow", rq[15:8], 8'h06);
		cmd(8'h30, 1'b0, 1'b0);
		check("wide_back", wide, 1'b1);
		$display("test narrow done");
		conclude();
	end
endmodule
`default_nettype wire
